/* File: hw/usbs_ep0_sel.v */
`timescale 1ns/1ps
`include "usbs_defs.vh"

// Summary of operation
// - status bit 3 shows last received toggle
// - setup token on endpoint 0 sets bit 2
// - later in or out keep setup set
// - only software write or reset clears setup
// - in token sets bit 1, others clear
// - out token sets bit 0, others clear
// - usb re-enable clears toggle, in, out
// - all endpoints share one window via select
// - fifo window accesses go to selected fifo
// - control register acts on selected endpoint
// - select bit 7: 0 in, 1 out
// - select bits 2:0 pick endpoint 0 to 4
// - select register resets to zero
// - control bits: enable, stall, toggle, busy
// - control register resets to 0x08
// - engine ignores tokens while usb disabled
// - every fifo comes up enabled after reset
module usbs_ep0_sel (
  input wire aclk, // system clock, 50 MHz
  input wire aresetn, // synchronous reset, active low
  input wire [9:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [9:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire tok_valid, // token received pulse
  input wire [1:0] tok_kind, // token type code
  input wire [2:0] tok_endpoint, // token endpoint number
  input wire pkt_valid, // data packet received pulse
  input wire [2:0] pkt_endpoint, // data packet endpoint number
  input wire pkt_toggle, // data packet toggle, 1 = DATA1
  input wire [9:0] endpoint_busy, // busy per fifo slot from engine
  input wire xdata_rd, // cpu read of fifo window, pulse
  input wire xdata_wr, // cpu write of fifo window, pulse
  output reg [9:0] fifo_rd_strobe, // read strobe to the selected fifo
  output reg [9:0] fifo_wr_strobe, // write strobe to the selected fifo
  output reg [9:0] ep_enable, // enable per fifo slot
  output reg [9:0] ep_stall, // stall per fifo slot
  output reg [9:0] ep_toggle, // toggle per fifo slot
  output reg usb_function_enable, // serial engine enable
  output reg fifo_visible, // fifo window visible
  output reg remote_wakeup, // force resume on the bus
  output reg irq // level interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // slot index: in fifos 0..4, out fifos 5..9
  function [3:0] slot_of;
    input dir;
    input [2:0] ep;
    begin
      slot_of = dir ? ({1'b0, ep} + `USBS_EP_COUNT) : {1'b0, ep};
    end
  endfunction

  // register index match on a byte address
  function reg_hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      reg_hit = (addr[9:2] == idx);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  reg rx_toggle_flag;
  reg setup_flag;
  reg in_flag;
  reg out_flag;
  reg [7:0] endpoint_select;
  reg [2:0] irq_status;
  reg [2:0] irq_enable;
  reg aw_got;
  reg w_got;
  reg [9:0] wr_addr;
  reg [7:0] wr_byte;
  reg wr_lane0;

  // reset images kept whole so single bits are picked, not truncated
  localparam [7:0] uc_reset_val = `USBS_UC_RESET;
  localparam [7:0] ctl_reset_val = `USBS_CTL_RESET;

  wire sel_dir = endpoint_select[`USBS_SEL_DIR];
  wire [2:0] sel_ep = endpoint_select[`USBS_SEL_EP_HI:`USBS_SEL_EP_LO];
  wire sel_ok = (sel_ep <= `USBS_EP_MAX);
  wire [3:0] sel_slot = slot_of(sel_dir, sel_ep);

  // tokens count only while the function is enabled
  wire tok_ep0 = tok_valid & usb_function_enable & (tok_endpoint == 3'h0);
  wire tok_setup = tok_ep0 & (tok_kind == `USBS_TOK_SETUP);
  wire tok_in = tok_ep0 & (tok_kind == `USBS_TOK_IN);
  wire tok_out = tok_ep0 & (tok_kind == `USBS_TOK_OUT);
  wire pkt_ep0 = pkt_valid & usb_function_enable & (pkt_endpoint == 3'h0);

  wire do_write = aw_got & w_got & ~s_axi_bvalid;
  wire wr_ok = wr_lane0;
  wire w_uc = do_write & wr_ok & reg_hit(wr_addr, `USBS_IDX_USB_CONTROL);
  wire w_st = do_write & wr_ok & reg_hit(wr_addr, `USBS_IDX_EP0_STATUS);
  wire w_sel = do_write & wr_ok & reg_hit(wr_addr, `USBS_IDX_EP_SELECT);
  wire w_ctl = do_write & wr_ok & reg_hit(wr_addr, `USBS_IDX_EP_CONTROL);
  wire w_clr = do_write & wr_ok & reg_hit(wr_addr, `USBS_IDX_IRQ_CLEAR);
  wire w_en = do_write & wr_ok & reg_hit(wr_addr, `USBS_IDX_IRQ_ENABLE);
  wire wr_mapped = reg_hit(wr_addr, `USBS_IDX_USB_CONTROL) |
                   reg_hit(wr_addr, `USBS_IDX_EP0_STATUS) |
                   reg_hit(wr_addr, `USBS_IDX_EP_SELECT) |
                   reg_hit(wr_addr, `USBS_IDX_EP_CONTROL) |
                   reg_hit(wr_addr, `USBS_IDX_IRQ_STATUS) |
                   reg_hit(wr_addr, `USBS_IDX_IRQ_CLEAR) |
                   reg_hit(wr_addr, `USBS_IDX_IRQ_ENABLE);

  // a 0 to 1 write of the enable bit is the re-enable that wipes toggle, in and out
  wire reenable = w_uc & wr_byte[`USBS_UC_ENABLE] & ~usb_function_enable;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: one write in flight, address and data in any order

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USBS_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= 10'h000;
      wr_byte <= 8'h00;
      wr_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wr_byte <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `USBS_RESP_OKAY : `USBS_RESP_SLVERR;
      end
      // ready comes back only once the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel; reserved bits read as zero

  reg [7:0] rd_byte;
  reg rd_mapped;
  always @* begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    if (reg_hit(s_axi_araddr, `USBS_IDX_USB_CONTROL)) begin
      rd_byte[`USBS_UC_ENABLE] = usb_function_enable;
      rd_byte[`USBS_UC_VISIBLE] = fifo_visible;
      rd_byte[`USBS_UC_WAKEUP] = remote_wakeup;
    end else if (reg_hit(s_axi_araddr, `USBS_IDX_EP0_STATUS)) begin
      rd_byte[`USBS_ST_RX_TOGGLE] = rx_toggle_flag;
      rd_byte[`USBS_ST_SETUP] = setup_flag;
      rd_byte[`USBS_ST_IN] = in_flag;
      rd_byte[`USBS_ST_OUT] = out_flag;
    end else if (reg_hit(s_axi_araddr, `USBS_IDX_EP_SELECT)) begin
      rd_byte[`USBS_SEL_DIR] = sel_dir;
      rd_byte[`USBS_SEL_EP_HI:`USBS_SEL_EP_LO] = sel_ep;
    end else if (reg_hit(s_axi_araddr, `USBS_IDX_EP_CONTROL)) begin
      if (sel_ok) begin
        rd_byte[`USBS_CTL_ENABLE] = ep_enable[sel_slot];
        rd_byte[`USBS_CTL_STALL] = ep_stall[sel_slot];
        rd_byte[`USBS_CTL_TOGGLE] = ep_toggle[sel_slot];
        rd_byte[`USBS_CTL_BUSY] = endpoint_busy[sel_slot];
      end
    end else if (reg_hit(s_axi_araddr, `USBS_IDX_IRQ_STATUS)) begin
      rd_byte[2:0] = irq_status;
    end else if (reg_hit(s_axi_araddr, `USBS_IDX_IRQ_ENABLE)) begin
      rd_byte[2:0] = irq_enable;
    end else if (!reg_hit(s_axi_araddr, `USBS_IDX_IRQ_CLEAR)) begin
      rd_mapped = 1'b0;
    end
  end

  // data is captured at the address handshake, so it is a one-cycle answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `USBS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_mapped ? `USBS_RESP_OKAY : `USBS_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // usb_control and endpoint_select

  always @(posedge aclk) begin
    if (!aresetn) begin
      usb_function_enable <= uc_reset_val[`USBS_UC_ENABLE];
      fifo_visible <= uc_reset_val[`USBS_UC_VISIBLE];
      remote_wakeup <= uc_reset_val[`USBS_UC_WAKEUP];
      endpoint_select <= `USBS_SEL_RESET;
    end else begin
      if (w_uc) begin
        usb_function_enable <= wr_byte[`USBS_UC_ENABLE];
        fifo_visible <= wr_byte[`USBS_UC_VISIBLE];
        remote_wakeup <= wr_byte[`USBS_UC_WAKEUP];
      end
      // only direction and endpoint bits are stored
      if (w_sel) begin
        endpoint_select <= wr_byte & 8'h87;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // endpoint 0 token status

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_toggle_flag <= 1'b0;
      setup_flag <= 1'b0;
      in_flag <= 1'b0;
      out_flag <= 1'b0;
    end else begin
      // a re-enable wipes toggle, in and out but leaves setup alone
      if (reenable) begin
        rx_toggle_flag <= 1'b0;
        in_flag <= 1'b0;
        out_flag <= 1'b0;
      end else begin
        if (pkt_ep0) begin
          rx_toggle_flag <= pkt_toggle;
        end
        if (tok_in) begin
          in_flag <= 1'b1;
        end else if (tok_setup || tok_out) begin
          in_flag <= 1'b0;
        end
        if (tok_out) begin
          out_flag <= 1'b1;
        end else if (tok_setup || tok_in) begin
          out_flag <= 1'b0;
        end
      end
      // setup is cleared only by software; a token in the same cycle wins
      // in and out tokens never touch setup_flag
      if (tok_setup) begin
        setup_flag <= 1'b1;
      end else if (w_st) begin
        setup_flag <= wr_byte[`USBS_ST_SETUP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-slot endpoint control; writes land on the selected slot only

  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < `USBS_SLOTS; i = i + 1) begin
        ep_enable[i] <= ctl_reset_val[`USBS_CTL_ENABLE];
        ep_stall[i] <= ctl_reset_val[`USBS_CTL_STALL];
        ep_toggle[i] <= ctl_reset_val[`USBS_CTL_TOGGLE];
      end
    end else if (w_ctl && sel_ok) begin
      ep_enable[sel_slot] <= wr_byte[`USBS_CTL_ENABLE];
      ep_stall[sel_slot] <= wr_byte[`USBS_CTL_STALL];
      ep_toggle[sel_slot] <= wr_byte[`USBS_CTL_TOGGLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fifo window routing; endpoints 5-7 reach nothing

  always @(posedge aclk) begin
    if (!aresetn) begin
      fifo_rd_strobe <= 10'h000;
      fifo_wr_strobe <= 10'h000;
    end else begin
      fifo_rd_strobe <= 10'h000;
      fifo_wr_strobe <= 10'h000;
      if (sel_ok && xdata_rd) begin
        fifo_rd_strobe[sel_slot] <= 1'b1;
      end
      if (sel_ok && xdata_wr) begin
        fifo_wr_strobe[sel_slot] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky token events, write-one clear, set beats clear

  wire [2:0] irq_set = {tok_setup, tok_in, tok_out};
  wire [2:0] irq_clr = w_clr ? wr_byte[2:0] : 3'h0;
  wire [2:0] next_irq_status = irq_set | (irq_status & ~irq_clr);
  wire [2:0] next_irq_enable = w_en ? wr_byte[2:0] : irq_enable;

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      irq <= |(next_irq_status & next_irq_enable);
    end
  end

endmodule // usbs_ep0_sel

/* File: pkg/usbs_defs.vh */
`ifndef USBS_DEFS_VH
`define USBS_DEFS_VH

// register indices; byte address is four times the index
`define USBS_IDX_USB_CONTROL 8'hec
`define USBS_IDX_EP0_STATUS 8'hed
`define USBS_IDX_EP_SELECT 8'hef
`define USBS_IDX_EP_CONTROL 8'hf1
`define USBS_IDX_IRQ_STATUS 8'hf8
`define USBS_IDX_IRQ_CLEAR 8'hf9
`define USBS_IDX_IRQ_ENABLE 8'hfa

// ep0_token_status fields
`define USBS_ST_RX_TOGGLE 3
`define USBS_ST_SETUP 2
`define USBS_ST_IN 1
`define USBS_ST_OUT 0

// endpoint_select fields and reset value
`define USBS_SEL_DIR 7
`define USBS_SEL_EP_HI 2
`define USBS_SEL_EP_LO 0
`define USBS_SEL_RESET 8'h00
`define USBS_EP_MAX 3'h4
`define USBS_EP_COUNT 4'h5

// endpoint_control fields and reset value
`define USBS_CTL_ENABLE 3
`define USBS_CTL_STALL 2
`define USBS_CTL_TOGGLE 1
`define USBS_CTL_BUSY 0
`define USBS_CTL_RESET 8'h08

// usb_control fields and reset value
`define USBS_UC_ENABLE 2
`define USBS_UC_VISIBLE 1
`define USBS_UC_WAKEUP 0
`define USBS_UC_RESET 8'h00

// interrupt status bits: setup, in, out token seen on endpoint 0
`define USBS_IRQ_SETUP 2
`define USBS_IRQ_IN 1
`define USBS_IRQ_OUT 0

// token codes from the serial engine
`define USBS_TOK_OUT 2'h0
`define USBS_TOK_IN 2'h1
`define USBS_TOK_SETUP 2'h2

// number of FIFO slots: five endpoints, two directions
`define USBS_SLOTS 10

// AXI responses
`define USBS_RESP_OKAY 2'h0
`define USBS_RESP_SLVERR 2'h2

`endif

/* File: test/usbs_ep0_sel_props.sv */
`timescale 1ns/1ps
module usbs_ep0_sel_props (
  input wire aclk, // clock
  input wire aresetn, // reset, active low
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire [1:0] s_axi_bresp, // b resp
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata, // r data
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire xdata_rd, // window read
  input wire xdata_wr, // window write
  input wire [9:0] fifo_rd_strobe, // read strobes
  input wire [9:0] fifo_wr_strobe, // write strobes
  input wire [9:0] ep_enable, // slot enables
  input wire [9:0] ep_stall, // slot stalls
  input wire [9:0] ep_toggle // slot toggles
);
  // one domain, so clock and reset are named once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // strobes only follow a window access and hit one slot
  a_rd_strobe_cause: assert property (
    fifo_rd_strobe != 10'h0 |-> $past(xdata_rd) && $onehot(fifo_rd_strobe))
    else $error("read strobe without window read");
  a_wr_strobe_cause: assert property (
    fifo_wr_strobe != 10'h0 |-> $past(xdata_wr) && $onehot(fifo_wr_strobe))
    else $error("write strobe without window write");
  a_same_slot: assert property (
    xdata_rd && xdata_wr |=> fifo_rd_strobe == fifo_wr_strobe)
    else $error("read and write reach different slots");
  a_slots_up: assert property (
    $rose(aresetn) |-> ep_enable == 10'h3ff && ep_stall == 10'h0 && ep_toggle == 10'h0)
    else $error("slots not at reset state");
  // write answer two cycles after both handshakes, read answer one; both then hold
  a_b_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write response");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read response");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // usbs_ep0_sel_props
bind usbs_ep0_sel usbs_ep0_sel_props u_props (.*);

/* File: test/usbs_host_model.sv */
`timescale 1ns/1ps
module usbs_host_model (
  input wire aclk, // clock
  output reg tok_valid = 1'b0, // token pulse
  output reg [1:0] tok_kind = 2'h0, // token code
  output reg [2:0] tok_endpoint = 3'h0, // token endpoint
  output reg pkt_valid = 1'b0, // packet pulse
  output reg [2:0] pkt_endpoint = 3'h0, // packet endpoint
  output reg pkt_toggle = 1'b0, // packet toggle
  output reg [9:0] endpoint_busy = 10'h0 // busy per slot
);
  // idle lines show the inverse, so a stale value never looks like a token
  task send_token(input [1:0] kind, input [2:0] ep);
    @(posedge aclk);
    tok_valid <= 1'b1;
    tok_kind <= kind;
    tok_endpoint <= ep;
    @(posedge aclk);
    tok_valid <= 1'b0;
    tok_kind <= ~kind;
    tok_endpoint <= ~ep;
  endtask
  task send_packet(input [2:0] ep, input tg);
    @(posedge aclk);
    pkt_valid <= 1'b1;
    pkt_endpoint <= ep;
    pkt_toggle <= tg;
    @(posedge aclk);
    pkt_valid <= 1'b0;
    pkt_endpoint <= ~ep;
    pkt_toggle <= ~tg;
  endtask
  task set_busy(input [9:0] b);
    @(posedge aclk);
    endpoint_busy <= b;
  endtask
endmodule // usbs_host_model

/* File: test/usbs_ep0_sel_test.sv */
`timescale 1ns/1ps
`include "usbs_defs.vh"
module usbs_ep0_sel_test;
  localparam [7:0] ST = `USBS_IDX_EP0_STATUS;
  localparam [7:0] SEL = `USBS_IDX_EP_SELECT;
  localparam [7:0] CTL = `USBS_IDX_EP_CONTROL;
  localparam [7:0] UC = `USBS_IDX_USB_CONTROL;
  localparam [1:0] OK = `USBS_RESP_OKAY;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, xdata_rd = 1'b0, xdata_wr = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp, tok_kind;
  wire [31:0] s_axi_rdata;
  wire tok_valid, pkt_valid, pkt_toggle, usb_function_enable, fifo_visible, remote_wakeup;
  wire [2:0] tok_endpoint, pkt_endpoint;
  wire [9:0] endpoint_busy, fifo_rd_strobe, fifo_wr_strobe, ep_enable, ep_stall, ep_toggle;
  integer seed = 32'ha555;
  integer fails = 0;
  integer samples_checked = 0;
  integer i;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [19:0] sq[$];
  reg [7:0] st, v;
  reg [3:0] slot;
  reg [2:0] irqs, ep;
  reg [1:0] k;
  reg tg;
  always #10 aclk = ~aclk;
  usbs_ep0_sel dut (.*);
  usbs_host_model host (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ready may come late, so the bus waits are never counted in cycles
  task wr(input [7:0] idx, input [7:0] d, input [1:0] er);
    bq.push_back(er);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= ($random(seed) & 32'hffffff00) | {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= ($random(seed) & 1) != 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      s_axi_bready <= s_axi_bready || (($random(seed) & 1) != 0);
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] idx, input [7:0] d, input [1:0] er);
    rq.push_back({er, 24'h0, d});
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= ($random(seed) & 1) != 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= s_axi_rready || (($random(seed) & 1) != 0);
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // results are matched in order; an unexpected one meets an all-ones note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("read", {s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : '1);
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", s_axi_bresp, bq.size() ? bq.pop_front() : '1);
    if ((fifo_rd_strobe | fifo_wr_strobe) != 10'h0)
      chk("strobe", {fifo_rd_strobe, fifo_wr_strobe}, sq.size() ? sq.pop_front() : '1);
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SEL, 8'h00, OK);
    rd(CTL, 8'h08, OK);
    rd(8'h00, 8'h00, `USBS_RESP_SLVERR);
    wr(8'h01, 8'hff, `USBS_RESP_SLVERR);
    host.send_token(`USBS_TOK_SETUP, 3'h0);
    rd(ST, 8'h00, OK);
    wr(UC, 8'h04, OK);
    wr(`USBS_IDX_IRQ_ENABLE, 8'h07, OK);
    st = 8'h00;
    irqs = 3'h0;
    // first three cover every token kind, then random ones, some off endpoint 0
    for (i = 0; i < 14; i++) begin
      k = (i < 3) ? i : $unsigned($random(seed)) % 3;
      ep = (i % 4 == 3) ? 3'h3 : 3'h0;
      tg = $random(seed);
      host.send_token(k, ep);
      host.send_packet(ep, tg);
      if (ep == 3'h0) begin
        st[1:0] = (k == `USBS_TOK_IN) ? 2'b10 : (k == `USBS_TOK_OUT) ? 2'b01 : 2'b00;
        st[3] = tg;
        if (k == `USBS_TOK_SETUP) st[2] = 1'b1;
        irqs[k] = 1'b1;
      end
      rd(ST, st, OK);
    end
    rd(`USBS_IDX_IRQ_STATUS, {5'h0, irqs}, OK);
    @(negedge aclk);
    chk("irq", irq, 1'b1);
    wr(`USBS_IDX_IRQ_ENABLE, 8'h00, OK);
    @(negedge aclk);
    chk("irq", irq, 1'b0);
    wr(`USBS_IDX_IRQ_CLEAR, 8'h07, OK);
    rd(`USBS_IDX_IRQ_STATUS, 8'h00, OK);
    rd(`USBS_IDX_IRQ_CLEAR, 8'h00, OK);
    host.send_token(`USBS_TOK_OUT, 3'h0);
    host.send_packet(3'h0, 1'b1);
    wr(ST, 8'hff, OK);
    rd(ST, 8'h0d, OK);
    wr(UC, 8'h00, OK);
    host.send_token(`USBS_TOK_IN, 3'h0);
    wr(UC, 8'hff, OK);
    rd(ST, 8'h04, OK);
    rd(UC, 8'h07, OK);
    chk("uc pins", {usb_function_enable, fifo_visible, remote_wakeup}, 3'h7);
    wr(ST, 8'h00, OK);
    rd(ST, 8'h00, OK);
    host.set_busy($random(seed));
    // every direction and endpoint code, reserved select bits randomised
    for (i = 0; i < 16; i++) begin
      ep = i[2:0];
      v = {i[3], 4'h0, ep};
      slot = i[3] ? 4'd5 + ep : {1'b0, ep};
      wr(SEL, v | ($random(seed) & 8'h78), OK);
      rd(SEL, v, OK);
      wr(CTL, 8'hfe, OK);
      rd(CTL, ep < 5 ? {7'h07, endpoint_busy[slot]} : 8'h00, OK);
      if (ep < 5) sq.push_back({ep[0] ? 10'h0 : 10'h1 << slot, 10'h1 << slot});
      @(posedge aclk);
      xdata_rd <= !ep[0];
      xdata_wr <= 1'b1;
      @(posedge aclk);
      xdata_rd <= 1'b0;
      xdata_wr <= 1'b0;
    end
    repeat (2) @(posedge aclk);
    chk("slots", {ep_enable, ep_stall, ep_toggle}, 30'h3fffffff);
    chk("left", rq.size() + bq.size() + sq.size(), 0);
    summarize;
  end
endmodule // usbs_ep0_sel_test
